// [src/qsd_pkg.sv]
/*
 * Constants, register map and state codes of the qualified sync and
 * dynamic digital delay block.
 * Assumes one clock, aclk, that is the clock distribution path clock.
 */
`default_nettype none

package qsd_pkg;

	localparam int GROUPS = 3;

	// --------------------------------------------------------------
	// Register map
	// --------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_GROUP0 = 8'h04;
	localparam logic [7:0] OFS_GROUP1 = 8'h08;
	localparam logic [7:0] OFS_GROUP2 = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	localparam int CTRL_QUALIFY = 0;
	localparam int CTRL_POL_INV = 1;
	localparam int CTRL_AUTO = 2;
	localparam int CTRL_FB_EN = 3;
	localparam int CTRL_FB_SEL = 4;
	localparam int CTRL_PD45 = 6;
	localparam int CTRL_SYNC_EN = 7;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0080;

	localparam int GRP_DIV = 0;
	localparam int GRP_DLY = 8;
	localparam int GRP_HS = 16;
	localparam int GRP_EXEMPT = 17;
	localparam logic [31:0] GROUP_RESET = 32'h0000_0502;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// --------------------------------------------------------------
	// Timing in distribution path cycles
	// --------------------------------------------------------------
	localparam logic [9:0] PULSE_START = 10'h003;
	localparam logic [9:0] PULSE_WIDTH = 10'h003;
	localparam logic [9:0] FORCE_LOW = 10'h005;
	localparam logic [9:0] RISE_BASE = 10'h005;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_WAIT1 = 4'h2,
		ST_WAIT2 = 4'h4,
		ST_SEQ = 4'h8
	} qsd_state_t;

endpackage : qsd_pkg

`default_nettype wire

// [src/qsd_top.sv]
/*
 * Qualified sync engine with three output divider groups, behind an
 * AXI4-Lite register slave.
 * Assumes aclk is the distribution path clock and sync_in is synchronous.
 */
`timescale 1ns/1ps
`default_nettype none

module qsd_top (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic sync_in,
	output logic [2:0] group_clk,
	output logic [2:0] group_half_step,
	output logic one_shot
);

	// --------------------------------------------------------------
	// Helpers
	// --------------------------------------------------------------
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	function automatic logic div_high(input logic [7:0] cnt, input logic [7:0] div);
		logic [8:0] half;
		half = ({1'b0, div} + 9'h001) >> 1;
		return (div < 8'h02) || ({1'b0, cnt} < half);
	endfunction : div_high

	// --------------------------------------------------------------
	// Register bus
	// --------------------------------------------------------------
	logic aw_have_q;
	logic w_have_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [31:0] rdata_q;
	logic [1:0] rresp_q;
	logic [31:0] ctrl_q;
	logic [2:0][31:0] grp_q;

	wire do_write = aw_have_q && w_have_q && !bvalid_q;
	wire wr_ctrl = do_write && (aw_addr_q == qsd_pkg::OFS_CTRL);
	wire wr_g0 = do_write && (aw_addr_q == qsd_pkg::OFS_GROUP0);
	wire wr_g1 = do_write && (aw_addr_q == qsd_pkg::OFS_GROUP1);
	wire wr_g2 = do_write && (aw_addr_q == qsd_pkg::OFS_GROUP2);
	wire [2:0] wr_grp = {wr_g2, wr_g1, wr_g0};
	wire wr_hit = wr_ctrl || (|wr_grp);
	wire wr_status = do_write && (aw_addr_q == qsd_pkg::OFS_STATUS);

	assign s_axi_awready = !aw_have_q;
	assign s_axi_wready = !w_have_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_arready = !rvalid_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rdata = rdata_q;
	assign s_axi_rresp = rresp_q;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q <= 1'b0;
			w_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_have_q) begin
				aw_have_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end else if (do_write) begin
				aw_have_q <= 1'b0;
			end
			if (s_axi_wvalid && !w_have_q) begin
				w_have_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end else if (do_write) begin
				w_have_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid_q <= 1'b0;
			bresp_q <= qsd_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid_q <= 1'b1;
			bresp_q <= (wr_hit || wr_status) ? qsd_pkg::RESP_OKAY : qsd_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_q <= 1'b0;
		end
	end

	// Writes to a group register stage the delay count, while divider and half-step act at once;
	// the live count is copied at the start of a sync sequence.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_q <= qsd_pkg::CTRL_RESET;
			grp_q <= {3{qsd_pkg::GROUP_RESET}};
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= merge(ctrl_q, w_data_q, w_strb_q);
			end
			for (int g = 0; g < qsd_pkg::GROUPS; g++) begin
				if (wr_grp[g]) begin
					grp_q[g] <= merge(grp_q[g], w_data_q, w_strb_q);
				end
			end
		end
	end

	// --------------------------------------------------------------
	// Control fields
	// --------------------------------------------------------------
	wire qual_en = ctrl_q[qsd_pkg::CTRL_QUALIFY] && ctrl_q[qsd_pkg::CTRL_FB_EN]
		&& !ctrl_q[qsd_pkg::CTRL_PD45];
	wire pol_inv = ctrl_q[qsd_pkg::CTRL_POL_INV];
	wire auto_en = ctrl_q[qsd_pkg::CTRL_AUTO];
	wire sync_en = ctrl_q[qsd_pkg::CTRL_SYNC_EN];
	wire [1:0] fb_sel = ctrl_q[qsd_pkg::CTRL_FB_SEL +: 2];

	logic [2:0] exempt;
	logic [2:0][7:0] div_val;
	logic [2:0][7:0] dly_new;
	always_comb begin
		for (int g = 0; g < qsd_pkg::GROUPS; g++) begin
			exempt[g] = grp_q[g][qsd_pkg::GRP_EXEMPT];
			div_val[g] = grp_q[g][qsd_pkg::GRP_DIV +: 8];
			dly_new[g] = grp_q[g][qsd_pkg::GRP_DLY +: 8];
			group_half_step[g] = grp_q[g][qsd_pkg::GRP_HS];
		end
	end

	// --------------------------------------------------------------
	// Sync request and qualification
	// --------------------------------------------------------------
	qsd_pkg::qsd_state_t st_q;
	qsd_pkg::qsd_state_t st_d;
	logic lvl_q;
	logic pend_q;
	logic qual_prev_q;
	logic [9:0] tmr_q;
	logic [2:0] part_q;
	logic [2:0] hold_q;
	logic [2:0][7:0] dly_act_q;
	logic [2:0][7:0] cnt_q;
	logic [2:0] grp_clk_q;

	wire lvl = sync_in ^ pol_inv;
	wire pin_edge = lvl && !lvl_q;
	wire auto_req = auto_en && (|wr_grp);
	wire take = (st_q == qsd_pkg::ST_IDLE) && pend_q && sync_en;
	wire qual_clk = (fb_sel == 2'h0) ? grp_clk_q[0] : (fb_sel == 2'h1) ? grp_clk_q[1]
		: grp_clk_q[2];
	wire qfall = qual_prev_q && !qual_clk;
	wire enter_seq = (st_q != qsd_pkg::ST_SEQ) && (st_d == qsd_pkg::ST_SEQ);
	wire seq_done = (tmr_q > qsd_pkg::PULSE_START + qsd_pkg::FORCE_LOW) && (hold_q == 3'h0);

	assign one_shot = (st_q == qsd_pkg::ST_SEQ) && (tmr_q >= qsd_pkg::PULSE_START)
		&& (tmr_q < qsd_pkg::PULSE_START + qsd_pkg::PULSE_WIDTH);

	always_comb begin
		st_d = st_q;
		case (st_q)
			qsd_pkg::ST_IDLE: begin
				if (take) begin
					st_d = qual_en ? qsd_pkg::ST_WAIT1 : qsd_pkg::ST_SEQ;
				end
			end
			qsd_pkg::ST_WAIT1: begin
				if (qfall) begin
					st_d = qsd_pkg::ST_WAIT2;
				end
			end
			qsd_pkg::ST_WAIT2: begin
				if (qfall) begin
					st_d = qsd_pkg::ST_SEQ;
				end
			end
			qsd_pkg::ST_SEQ: begin
				if (seq_done) begin
					st_d = qsd_pkg::ST_IDLE;
				end
			end
			default: st_d = qsd_pkg::ST_IDLE;
		endcase
	end

	// A request that lands while a sequence runs is kept and served next.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_q <= qsd_pkg::ST_IDLE;
			lvl_q <= 1'b0;
			pend_q <= 1'b0;
			qual_prev_q <= 1'b0;
			tmr_q <= 10'h000;
		end else begin
			st_q <= st_d;
			lvl_q <= lvl;
			pend_q <= pin_edge || auto_req || (pend_q && !take);
			qual_prev_q <= qual_clk;
			tmr_q <= enter_seq ? 10'h000 : (tmr_q + 10'h001);
		end
	end

	// --------------------------------------------------------------
	// Output groups
	// --------------------------------------------------------------
	logic [2:0] hold_d;
	logic [2:0][7:0] cnt_d;
	logic [2:0] force_now;
	logic [2:0] release_now;
	always_comb begin
		for (int g = 0; g < qsd_pkg::GROUPS; g++) begin
			force_now[g] = (st_q == qsd_pkg::ST_SEQ) && part_q[g]
				&& (tmr_q == qsd_pkg::PULSE_START + qsd_pkg::FORCE_LOW - 10'h001);
			release_now[g] = (st_q == qsd_pkg::ST_SEQ) && hold_q[g] && (tmr_q ==
				qsd_pkg::PULSE_START + qsd_pkg::PULSE_WIDTH + qsd_pkg::RISE_BASE
				+ {2'h0, dly_act_q[g]} - 10'h001);
			hold_d[g] = force_now[g] || (hold_q[g] && !release_now[g]);
			// A released group restarts at zero so that it rises on its release edge.
			if (hold_d[g] || hold_q[g] || cnt_q[g] + 8'h01 >= div_val[g]) begin
				cnt_d[g] = 8'h00;
			end else begin
				cnt_d[g] = cnt_q[g] + 8'h01;
			end
		end
	end

	// Exempt groups never enter the hold, so they keep toggling.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			part_q <= 3'h0;
			hold_q <= 3'h0;
			dly_act_q <= {3{qsd_pkg::GROUP_RESET[qsd_pkg::GRP_DLY +: 8]}};
			cnt_q <= {3{8'h00}};
			grp_clk_q <= 3'h0;
		end else begin
			if (enter_seq) begin
				part_q <= ~exempt;
				dly_act_q <= dly_new;
			end
			hold_q <= hold_d;
			cnt_q <= cnt_d;
			for (int g = 0; g < qsd_pkg::GROUPS; g++) begin
				grp_clk_q[g] <= !hold_d[g] && div_high(cnt_d[g], div_val[g]);
			end
		end
	end

	assign group_clk = grp_clk_q;

	// --------------------------------------------------------------
	// Read path
	// --------------------------------------------------------------
	wire [31:0] status = {24'h000000, 1'b0, hold_q, st_q};
	wire rd_hit = (s_axi_araddr == qsd_pkg::OFS_CTRL) || (s_axi_araddr == qsd_pkg::OFS_STATUS)
		|| (s_axi_araddr == qsd_pkg::OFS_GROUP0) || (s_axi_araddr == qsd_pkg::OFS_GROUP1)
		|| (s_axi_araddr == qsd_pkg::OFS_GROUP2);
	wire [31:0] rd_val = (s_axi_araddr == qsd_pkg::OFS_CTRL) ? ctrl_q
		: (s_axi_araddr == qsd_pkg::OFS_GROUP0) ? grp_q[0]
		: (s_axi_araddr == qsd_pkg::OFS_GROUP1) ? grp_q[1]
		: (s_axi_araddr == qsd_pkg::OFS_GROUP2) ? grp_q[2]
		: (s_axi_araddr == qsd_pkg::OFS_STATUS) ? status : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0000_0000;
			rresp_q <= qsd_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && !rvalid_q) begin
			rvalid_q <= 1'b1;
			rdata_q <= rd_val;
			rresp_q <= rd_hit ? qsd_pkg::RESP_OKAY : qsd_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_q <= 1'b0;
		end
	end

	// --------------------------------------------------------------
	// Assertions
	// --------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence seq_start_s;
		(st_q == qsd_pkg::ST_SEQ) && (tmr_q == 10'h000);
	endsequence

	sequence pulse_body_s;
		one_shot [*3] ##1 !one_shot;
	endsequence

	pulse_start_a: assert property (seq_start_s |-> !one_shot [*3] ##1 one_shot)
		else $error("one-shot did not start three cycles after qualification");

	pulse_width_a: assert property ($rose(one_shot) |-> pulse_body_s)
		else $error("one-shot width is not three cycles");

	force_low_a: assert property ($rose(one_shot) |-> ##5 ((grp_clk_q & part_q) == 3'h0)
		&& (hold_q == part_q))
		else $error("synced groups not forced low five cycles after pulse start");

	qual_edges_a: assert property ($rose(st_q == qsd_pkg::ST_SEQ) && $past(st_q)
		== qsd_pkg::ST_WAIT2 |-> $past(qfall))
		else $error("sequence began without second qualifying falling edge");

	exempt_run_a: assert property ((hold_q & exempt & ~part_q) == 3'h0
		&& (hold_q & ~part_q) == 3'h0)
		else $error("exempt group was held by sync");

	delay_apply_a: assert property (!$stable(dly_act_q) |-> $past(enter_seq))
		else $error("live delay changed without sync");

	auto_sync_a: assert property (auto_req && sync_en |=> pend_q
		|| st_q != qsd_pkg::ST_IDLE)
		else $error("group write did not raise auto sync");

	half_step_a: assert property (wr_grp[1] && w_strb_q[2] |=> group_half_step[1]
		== $past(w_data_q[qsd_pkg::GRP_HS]))
		else $error("half-step did not act at once");

	for (genvar g = 0; g < 3; g++) begin : g_rel
		release_a: assert property ($fell(hold_q[g]) |-> grp_clk_q[g] && tmr_q
			== qsd_pkg::PULSE_START + qsd_pkg::PULSE_WIDTH + qsd_pkg::RISE_BASE
			+ {2'h0, dly_act_q[g]})
			else $error("synced group rose at wrong time");
	end

endmodule : qsd_top

`default_nettype wire

// [tb/qsd_host_model.sv]
/*
 * Host side model that drives the sync pin of the qualified sync block.
 * Assumes one clock, aclk, and a request strobe from the testbench.
 */
`timescale 1ns/1ps
`default_nettype none

module qsd_host_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic go,
	input wire logic [3:0] hold,
	output logic sync_pin
);
	logic [3:0] cnt_q;

	// ----------------------------------------------------------------
	// Sync pin pulse
	// ----------------------------------------------------------------
	// The width is free because the block makes its own one-shot.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= 4'h0;
			sync_pin <= 1'b0;
		end else if (go) begin
			cnt_q <= hold;
			sync_pin <= 1'b1;
		end else if (cnt_q > 4'h1) begin
			cnt_q <= cnt_q - 4'h1;
		end else begin
			cnt_q <= 4'h0;
			sync_pin <= 1'b0;
		end
	end
endmodule : qsd_host_model

`default_nettype wire

// [tb/qsd_top_tb_top.sv]
/*
 * Self-checking testbench of the qualified sync block.
 * Assumes the register map and timing of the design package.
 */
`timescale 1ns/1ps
`default_nettype none

module qsd_top_tb_top;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, one_shot, sync_in;
	logic [1:0] bresp, rresp;
	logic [2:0] group_clk, group_half_step;
	logic go = 1'b0;
	logic [3:0] hold = 4'h1;
	int n_fail = 0, checks_done = 0, cyc = 0;

	always #50 aclk = ~aclk;

	qsd_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .sync_in(sync_in), .group_clk(group_clk),
		.group_half_step(group_half_step), .one_shot(one_shot));

	qsd_host_model host (.aclk(aclk), .aresetn(aresetn), .go(go), .hold(hold),
		.sync_pin(sync_in));

	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : end_sim

	// A hung handshake ends the run here rather than in silence.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_fail++;
			end_sim();
		end
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (aw && awready) begin
				aw = 1'b0;
				awvalid <= 1'b0;
			end
			if (w && wready) begin
				w = 1'b0;
				wvalid <= 1'b0;
			end
		end while (bvalid !== 1'b1);
		// Ready stays high between calls, so back-to-back calls never drive it twice at once.
		chk("bresp", 32'h0, {30'h0, bresp});
	endtask : axi_wr

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready) begin
				arvalid <= 1'b0;
			end
		end while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
	endtask : axi_rd

	// ----------------------------------------------------------------
	// Sync sequence
	// ----------------------------------------------------------------
	task automatic check_seq(input int g, input int d, input int ex);
		int n, k;
		logic [2:0] prev;
		n = 0;
		k = 0;
		while (one_shot !== 1'b1 && n < 300) begin
			@(posedge aclk);
			n++;
		end
		chk("one_shot start", 32'h1, {31'h0, one_shot});
		n = 0;
		while (one_shot === 1'b1 && n < 10) begin
			@(posedge aclk);
			n++;
		end
		chk("one_shot width", 32'h3, n);
		n = 0;
		for (int i = 1; i <= 5 + d; i++) begin
			prev = group_clk;
			@(posedge aclk);
			if (prev[ex] !== group_clk[ex]) k++;
			if (i >= 2 && i < 5 + d && group_clk[g] !== 1'b0) n++;
		end
		chk("held low", 32'h0, n);
		chk("rise after delay", 32'h1, {31'h0, group_clk[g]});
		chk("exempt toggles", 32'h1, {31'h0, k > 0});
	endtask : check_seq

	task automatic pin_sync(input logic [3:0] h);
		hold <= h;
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
	endtask : pin_sync

	task automatic test_reset;
		logic [31:0] d;
		logic [1:0] r;
		axi_rd(qsd_pkg::OFS_CTRL, d, r);
		chk("ctrl reset", qsd_pkg::CTRL_RESET, d);
		axi_rd(qsd_pkg::OFS_GROUP0, d, r);
		chk("group reset", qsd_pkg::GROUP_RESET, d);
		axi_rd(qsd_pkg::OFS_STATUS, d, r);
		chk("status idle", 32'h1, {28'h0, d[3:0]});
		axi_rd(8'h14, d, r);
		chk("unmapped resp", {30'h0, qsd_pkg::RESP_SLVERR}, {30'h0, r});
	endtask : test_reset

	task automatic test_staged;
		logic [31:0] d;
		logic [1:0] r;
		int n;
		axi_wr(qsd_pkg::OFS_GROUP2, 32'h0002_0502);
		axi_wr(qsd_pkg::OFS_GROUP1, 32'h0000_0702);
		axi_wr(qsd_pkg::OFS_GROUP0, 32'h0001_0502);
		@(posedge aclk);
		chk("half step now", 32'h1, {31'h0, group_half_step[0]});
		n = 0;
		repeat (20) begin
			@(posedge aclk);
			if (one_shot !== 1'b0) n++;
		end
		chk("no sync without request", 32'h0, n);
		axi_rd(qsd_pkg::OFS_STATUS, d, r);
		chk("still idle", 32'h1, {28'h0, d[3:0]});
	endtask : test_staged

	task automatic test_qualified;
		int f, s;
		logic [2:0] prev;
		f = 0;
		s = 0;
		// Auto sync goes off first, so the group writes below start nothing by themselves.
		axi_wr(qsd_pkg::OFS_CTRL, 32'h0000_00AB);
		axi_wr(qsd_pkg::OFS_GROUP2, 32'h0002_0508);
		axi_wr(qsd_pkg::OFS_GROUP1, 32'h0000_0602);
		pin_sync(4'h2);
		while (one_shot !== 1'b1 && s < 100) begin
			prev = group_clk;
			@(posedge aclk);
			s++;
			if (prev[2] === 1'b1 && group_clk[2] === 1'b0) begin
				f++;
				s = 0;
			end
		end
		chk("two qualifying falls", 32'h1, {31'h0, f >= 2});
		chk("start after fall", 32'h4, s);
		check_seq(1, 6, 2);
	endtask : test_qualified

	initial begin
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		test_reset();
		test_staged();
		pin_sync(4'h7);
		check_seq(1, 7, 2);
		axi_wr(qsd_pkg::OFS_CTRL, 32'h0000_0082);
		check_seq(0, 5, 2);
		axi_wr(qsd_pkg::OFS_CTRL, 32'h0000_0086);
		axi_wr(qsd_pkg::OFS_GROUP1, 32'h0000_0902);
		check_seq(1, 9, 2);
		test_qualified();
		end_sim();
	end
endmodule : qsd_top_tb_top

`default_nettype wire
